// >>> dv/smt_mem_model.sv
`timescale 1ns/1ps
// Memory stand-in: 64 words, folded by address, walk preloaded
module smt_mem_model
(
   input wire        clk,
   input wire        reset,
   input wire [25:0] mem_addr,
   input wire [31:0] mem_wdata,
   input wire        mem_write,
   input wire        mem_read,
   input wire        slow,
   input wire [25:0] bad_addr,
   output reg        mem_ack,
   output reg [31:0] mem_rdata,
   output reg        mem_rvalid
);
   reg [31:0] mem_reg [0:63]; // Folded storage
   reg [1:0]  wait_reg;       // Stall count in slow mode
   integer    i;
   // Preload so reads of unwritten words still match a walk
   initial
   begin
      mem_rdata = 32'h0;
      for (i = 0; i < 64; i = i + 1)
         mem_reg[i] = 32'h1 << (i % 32);
   end
   // Accept a request, store or answer one cycle later
   always @(posedge clk or posedge reset)
   begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= ~mem_rdata; // Idle bus never holds old data
      if (reset)
      begin
         mem_ack  <= 1'b0;
         wait_reg <= 2'h0;
      end
      else if (mem_ack)
      begin
         mem_ack  <= 1'b0;
         wait_reg <= 2'h0;
         if (mem_write)
            mem_reg[mem_addr[5:0]] <= mem_wdata;
         if (mem_read)
         begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= mem_reg[mem_addr[5:0]] ^
                          {31'h0, mem_addr == bad_addr};
         end
      end
      else if ((mem_write || mem_read) && (!slow || wait_reg == 2'h3))
         mem_ack <= 1'b1;
      else if (mem_write || mem_read)
         wait_reg <= wait_reg + 2'h1;
   end
endmodule

// >>> dv/smt_memory_test_properties.sv
`timescale 1ns/1ps
// Port-level checks of the memory self-test
module smt_memory_test_properties
#(
   parameter fifo_clock_halve_option = 1,
   parameter BLINK_CYCLES            = 20000000
)
(
   input wire        clk,
   input wire        reset,
   input wire [31:0] ctl_data,
   input wire        ctl_valid,
   input wire        ctl_ready,
   input wire [25:0] mem_addr,
   input wire [31:0] mem_wdata,
   input wire        mem_write,
   input wire        mem_read,
   input wire        mem_ack,
   input wire [31:0] mem_rdata,
   input wire        mem_rvalid,
   input wire [31:0] out_data,
   input wire        out_valid,
   input wire        out_full,
   input wire [3:0]  pattern_leds,
   input wire        clock_alive_indicator,
   input wire        fast_fifo_clock_flag,
   input wire        fifo_clock_domain_option
);
   reg  [3:0]  sel_reg;  // Pattern of the running iteration
   reg  [31:0] wd_reg;   // Write data one cycle ago
   reg         led_reg;  // Indicator one cycle ago
   reg  [31:0] gap_reg;  // Cycles since the last toggle
   reg         seen_reg; // First toggle after reset is unaligned
   wire        take  = ctl_valid && ctl_ready;
   wire        wstep = mem_write && mem_ack && mem_addr != 26'h3ffffff;
   wire [31:0] kval  = sel_reg == 4'h1 ? 32'hffffffff :
                       sel_reg == 4'h2 ? 32'h55555555 :
                       sel_reg == 4'h3 ? 32'haaaaaaaa : 32'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Pattern capture and blink spacing
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sel_reg  <= 4'h0;
         wd_reg   <= 32'h0;
         led_reg  <= 1'b0;
         gap_reg  <= 32'h0;
         seen_reg <= 1'b0;
      end
      else
      begin
         wd_reg  <= mem_wdata;
         led_reg <= clock_alive_indicator;
         if (take)
            sel_reg <= ctl_data[3:0];
         if (clock_alive_indicator != led_reg)
         begin
            gap_reg  <= 32'h1;
            seen_reg <= 1'b1;
         end
         else
            gap_reg <= gap_reg + 32'h1;
      end
   end
   write_start_a: assert property (take && ctl_data[4] |=>
      mem_write && mem_addr == 26'h0) else $error("write pass late");
   const_pat_a: assert property (mem_write && sel_reg != 4'h4 &&
      sel_reg != 4'h8 |-> mem_wdata == kval) else $error("bad constant");
   first_val_a: assert property (mem_write && mem_addr == 26'h0 &&
      (sel_reg == 4'h4 || sel_reg == 4'h8) |-> mem_wdata == {31'h0, sel_reg[3]})
      else $error("bad first value");
   count_step_a: assert property (wstep && sel_reg == 4'h4 |=>
      mem_wdata == wd_reg + 32'h1) else $error("count step wrong");
   walk_step_a: assert property (wstep && sel_reg == 4'h8 |=>
      mem_wdata == {wd_reg[30:0], wd_reg[31]}) else $error("walk step wrong");
   full_stall_a: assert property (out_full |-> !mem_read)
      else $error("read while full");
   echo_out_a: assert property (mem_rvalid |=> out_valid &&
      out_data == $past(mem_rdata)) else $error("read word not forwarded");
   error_hold_a: assert property (pattern_leds == 4'hf |=>
      pattern_leds == 4'hf) else $error("error lamps dropped");
   blink_gap_a: assert property (seen_reg &&
      clock_alive_indicator != led_reg |-> gap_reg == BLINK_CYCLES)
      else $error("blink spacing wrong");
   clock_flag_a: assert property (fast_fifo_clock_flag ==
      (fifo_clock_halve_option == 0) && fifo_clock_domain_option)
      else $error("clock flags wrong");
endmodule

bind smt_memory_test smt_memory_test_properties #(
   .fifo_clock_halve_option(fifo_clock_halve_option),
   .BLINK_CYCLES(BLINK_CYCLES)
) u_smt_memory_test_properties (
   .clk(clk), .reset(reset), .ctl_data(ctl_data), .ctl_valid(ctl_valid),
   .ctl_ready(ctl_ready), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_write(mem_write), .mem_read(mem_read), .mem_ack(mem_ack),
   .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .out_data(out_data),
   .out_valid(out_valid), .out_full(out_full), .pattern_leds(pattern_leds),
   .clock_alive_indicator(clock_alive_indicator),
   .fast_fifo_clock_flag(fast_fifo_clock_flag),
   .fifo_clock_domain_option(fifo_clock_domain_option)
);

// >>> dv/smt_memory_test_tb.sv
`timescale 1ns/1ps
// Host-side sequences against the self-test block
module smt_memory_test_tb;
   reg         clk, reset, ctl_valid, out_full, reg_write, reg_read, slow;
   reg  [31:0] ctl_data, reg_wdata;
   reg  [3:0]  reg_addr, c;
   reg  [25:0] bad_addr;
   wire        ctl_ready, mem_write, mem_read, mem_ack, mem_rvalid;
   wire        out_valid, alive, fast, domain, busy, irq;
   wire [25:0] mem_addr;
   wire [31:0] mem_wdata, mem_rdata, out_data, reg_rdata;
   wire [3:0]  pattern_leds;
   integer     errors, checks_done, i, n, k;
   smt_memory_test #(.fifo_clock_halve_option(1), .BLINK_CYCLES(8))
   u_smt_memory_test (.clk(clk), .reset(reset), .ctl_data(ctl_data),
      .ctl_valid(ctl_valid), .ctl_ready(ctl_ready), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_write(mem_write), .mem_read(mem_read),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
      .out_data(out_data), .out_valid(out_valid), .out_full(out_full),
      .pattern_leds(pattern_leds), .clock_alive_indicator(alive),
      .fast_fifo_clock_flag(fast), .fifo_clock_domain_option(domain),
      .busy(busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .irq(irq));
   smt_mem_model u_smt_mem_model (.clk(clk), .reset(reset),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_write(mem_write),
      .mem_read(mem_read), .slow(slow), .bad_addr(bad_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Expected word k of a pattern
   function [31:0] pat(input [3:0] p, input integer w);
      case (p)
         4'h1: pat = 32'hffffffff;
         4'h2: pat = 32'h55555555;
         4'h3: pat = 32'haaaaaaaa;
         4'h4: pat = w;
         4'h8: pat = 32'h1 << (w % 32);
         default: pat = 32'h0;
      endcase
   endfunction
   task chk(input [31:0] seen, input [31:0] want);
      begin
         checks_done = checks_done + 1;
         if (seen !== want)
         begin
            errors = errors + 1;
            $display("Error %0t: got %h want %h", $time, seen, want);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task rst;
      begin
         reset <= 1'b1;
         repeat (3) @(posedge clk);
         reset <= 1'b0;
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_write <= 1'b1;
         @(posedge clk);
         reg_write <= 1'b0;
      end
   endtask
   task rd(input [3:0] a, input [31:0] want);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_read <= 1'b1;
         @(posedge clk);
         reg_read <= 1'b0;
         #1 chk(reg_rdata, want);
      end
   endtask
   // One control word, held until the taking edge
   task send(input [31:0] w);
      begin
         @(posedge clk);
         ctl_data  <= w;
         ctl_valid <= 1'b1;
         #1 chk(32'(ctl_ready), 1);
         @(posedge clk);
         ctl_valid <= 1'b0;
         ctl_data  <= 32'h0;
      end
   endtask
   // First 34 words of a pass; in a read pass stalls the output side for 20 cycles
   task collect(input [3:0] p, input rdp);
      begin
         n = 0;
         for (k = 0; k < 3000 && n < 34; k = k + 1)
         begin
            @(posedge clk);
            out_full <= rdp && k >= 30 && k < 50;
            #1;
            if (rdp ? out_valid : mem_write && mem_ack)
            begin
               chk(rdp ? out_data : mem_wdata, pat(p, n));
               if (!rdp)
                  chk({6'h0, mem_addr}, n);
               n = n + 1;
            end
         end
         if (n < 34)
         begin
            errors = errors + 1;
            final_report;
         end
      end
   endtask
   initial
   begin
      reset = 1'b1;
      {ctl_valid, out_full, reg_write, reg_read, slow} = 5'h0;
      {ctl_data, reg_wdata, reg_addr} = 68'h0;
      bad_addr = 26'h3ffffff;
      errors = 0;
      checks_done = 0;
      rst;
      #1 chk({busy, fast, domain, pattern_leds}, 32'h10);
      rd(4'h0, 0);
      rd(4'h4, 0);
      rd(4'hc, 0);
      // Every code, write pass only, memory speed alternating
      for (i = 0; i < 6; i = i + 1)
      begin
         c = (i < 4) ? i[3:0] : (i == 4) ? 4'h4 : 4'h8;
         rst;
         slow <= i[0];
         send({26'h0, 2'b01, c});
         #1 chk({busy, pattern_leds}, {27'h0, 1'b1, c});
         collect(c, 1'b0);
      end
      // Read pass, slow memory, output side stalling
      rst;
      send(32'h28);
      collect(4'h8, 1'b1);
      chk(32'(pattern_leds), 8);
      // One corrupted word lights all lamps and raises the event
      rst;
      bad_addr <= 26'h3;
      send(32'h28);
      for (k = 0; k < 500 && pattern_leds !== 4'hf; k = k + 1)
         @(posedge clk);
      if (k == 500)
      begin
         errors = errors + 1;
         final_report;
      end
      out_full <= 1'b1;
      chk(32'(irq), 0);
      wr(4'h4, 32'h2);
      rd(4'h4, 32'h2);
      chk(32'(irq), 1);
      rd(4'h0, 32'h6);
      wr(4'h0, 32'h2);
      rd(4'h0, 32'h4);
      chk({irq, pattern_leds}, 32'hf);
      rst;
      #1 chk(32'(pattern_leds), 0);
      final_report;
   end
endmodule

// >>> pkg/smt_consts.vh
// How it works
// - Read pass emits 67108864 words out
// - Patterns zero and all ones
// - Patterns 55555555h and AAAAAAAAh
// - Fifth pattern counts up from zero
// - Sixth pattern walking one from one
// - Walking one wraps after top bit
// - Alive indicator toggles about once per second
// - Option selects direct or halved clock
// - Flag true when clock above 60 MHz
// - Control word: pattern, write, read bits
// - Pattern select codes as listed
// - Write all locations, then read and check
// - Mismatch lights all pattern LEDs until reset
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH
// Control word fields
`define SMT_SEL_LSB      0
`define SMT_SEL_MSB      3
`define SMT_WEN_BIT      4
`define SMT_REN_BIT      5
// Pattern select codes
`define SMT_PAT_ZERO     4'h0
`define SMT_PAT_ONES     4'h1
`define SMT_PAT_FIVES    4'h2
`define SMT_PAT_AS       4'h3
`define SMT_PAT_COUNT    4'h4
`define SMT_PAT_WALK     4'h8
// Pattern values
`define SMT_VAL_ZERO     32'h00000000
`define SMT_VAL_ONES     32'hffffffff
`define SMT_VAL_FIVES    32'h55555555
`define SMT_VAL_AS       32'haaaaaaaa
`define SMT_VAL_WALK0    32'h00000001
`define SMT_VAL_WTOP     32'h80000000
// Memory depth: 64M words, 26-bit address
`define SMT_ADDR_W       26
`define SMT_LAST_ADDR    26'h3ffffff
// Clock figures
`define SMT_OSC_HZ       100000000
`define SMT_FAST_HZ      60000000
`define SMT_BLINK_MS     1000
`endif

// >>> verilog/smt_blink.v
`timescale 1ns/1ps
`include "smt_consts.vh"
// Clock-alive blinker: toggles once per half period count
module smt_blink
#(
   parameter HALF_CYCLES = 20000000
)
(
   input  wire clk,
   input  wire reset,
   output wire led
);
   reg [31:0] cnt_reg;  // Cycles since last toggle
   reg        led_reg;  // Indicator level

   // Free-running toggle, about one second per change
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_reg <= 32'h00000000;
         led_reg <= 1'b0;
      end
      else if (cnt_reg >= HALF_CYCLES - 1)
      begin
         cnt_reg <= 32'h00000000;
         led_reg <= ~led_reg;
      end
      else
         cnt_reg <= cnt_reg + 32'h00000001;
   end

   assign led = led_reg;
endmodule

// >>> verilog/smt_memory_test.v
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "smt_consts.vh"
// Memory self-test control: takes a control word from the input
// stream, writes the memory with a pattern, reads it back, checks
// and streams every read word out.
module smt_memory_test
#(
   // Build option: halve the oscillator for the FIFO clock
   parameter fifo_clock_halve_option = 1,
   // Blink half period in cycles; shorten in simulation
   parameter BLINK_CYCLES = 20000000
)
(
   input  wire        clk,
   input  wire        reset,
   // Input control stream (same clock domain)
   input  wire [31:0] ctl_data,
   input  wire        ctl_valid,
   output wire        ctl_ready,
   // Memory port, simple request/acknowledge
   output wire [25:0] mem_addr,
   output wire [31:0] mem_wdata,
   output wire        mem_write,
   output wire        mem_read,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   input  wire        mem_rvalid,
   // Output stream of read words
   output wire [31:0] out_data,
   output wire        out_valid,
   input  wire        out_full,
   // Indicators and build-time flags
   output wire [3:0]  pattern_leds,
   output wire        clock_alive_indicator,
   output wire        fast_fifo_clock_flag,
   output wire        fifo_clock_domain_option,
   output wire        busy,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output wire [31:0] reg_rdata,
   output wire        irq
);
   // Register offsets
   localparam [3:0] A_STATUS = 4'h0;  // Sticky events, W1C
   localparam [3:0] A_MASK   = 4'h4;  // Interrupt mask
   localparam [3:0] A_STATE  = 4'h8;  // Live state and last control

   // Machine states
   localparam [2:0] S_IDLE  = 3'h0;
   localparam [2:0] S_WRITE = 3'h1;
   localparam [2:0] S_RSTRT = 3'h2;
   localparam [2:0] S_READ  = 3'h3;
   localparam [2:0] S_DRAIN = 3'h4;

   reg [2:0]  state_reg;     // Control state
   reg [25:0] addr_reg;      // Memory word address
   reg [3:0]  sel_reg;       // Pattern select
   reg        ren_reg;       // Read pass wanted
   reg        err_reg;       // Sticky mismatch, until reset
   reg        req_reg;       // Write request outstanding
   reg [31:0] out_data_reg;  // Output word
   reg        out_valid_reg; // Output strobe
   reg [25:0] rcnt_reg;      // Read words checked
   reg [2:0]  sts_reg;       // Sticky: done, error, word-out
   reg [2:0]  mask_reg;      // Interrupt mask
   reg [31:0] rdata_reg;     // Register read data
   reg        last_rd_reg;   // Last read request issued

   wire [31:0] wr_pat;       // Write-side pattern
   wire [31:0] ck_pat;       // Check-side pattern
   wire        take;         // Control word accepted
   wire        wr_step;      // Write accepted by memory
   wire        rd_step;      // Read data returned
   wire        mismatch;     // Returned word differs
   wire        done_ev;      // Read-pass iteration finished
   wire        err_ev;       // First mismatch event
   wire [3:0]  pat_sel;      // Select fed to both generators

   // Clock selection: frequency and the above-60 MHz flag follow it
   localparam integer FCLK_HZ = fifo_clock_halve_option ?
                                `SMT_OSC_HZ / 2 : `SMT_OSC_HZ;
   assign fast_fifo_clock_flag = (FCLK_HZ > `SMT_FAST_HZ);
   assign fifo_clock_domain_option = 1'b1;

   assign take    = (state_reg == S_IDLE) && ctl_valid;
   assign ctl_ready = (state_reg == S_IDLE);
   assign wr_step = (state_reg == S_WRITE) && req_reg && mem_ack;
   assign rd_step = (state_reg == S_READ || state_reg == S_DRAIN)
                    && mem_rvalid;
   assign mismatch = rd_step && (mem_rdata != ck_pat);
   assign err_ev   = mismatch && !err_reg;

   // Generators see the offered word only while it is taken, then the
   // stored select; a host that changes or clears its data word after
   // the hand-over must not bend a pattern that is still running
   assign pat_sel = take ? ctl_data[`SMT_SEL_MSB:`SMT_SEL_LSB]
                         : sel_reg;

   // Write-side and check-side pattern generators
   smt_pattern_gen u_wr_gen
   (
      .clk   (clk),
      .reset (reset),
      .load  (take),
      .sel   (pat_sel),
      .step  (wr_step),
      .value (wr_pat)
   );

   smt_pattern_gen u_ck_gen
   (
      .clk   (clk),
      .reset (reset),
      .load  (take),
      .sel   (pat_sel),
      .step  (rd_step),
      .value (ck_pat)
   );

   // Clock-alive indicator
   smt_blink #(.HALF_CYCLES(BLINK_CYCLES)) u_blink
   (
      .clk   (clk),
      .reset (reset),
      .led   (clock_alive_indicator)
   );

   // An iteration with a read pass ends with its last checked word
   assign done_ev = (state_reg == S_DRAIN) && rd_step &&
                    (rcnt_reg == `SMT_LAST_ADDR);

   // Control state machine
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_reg   <= S_IDLE;
         addr_reg    <= 26'h0000000;
         sel_reg     <= 4'h0;
         ren_reg     <= 1'b0;
         req_reg     <= 1'b0;
         rcnt_reg    <= 26'h0000000;
         last_rd_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            S_IDLE:
            begin
               if (take)
               begin
                  // Decode the control word
                  sel_reg  <= ctl_data[`SMT_SEL_MSB:`SMT_SEL_LSB];
                  ren_reg  <= ctl_data[`SMT_REN_BIT];
                  addr_reg <= 26'h0000000;
                  rcnt_reg <= 26'h0000000;
                  if (ctl_data[`SMT_WEN_BIT])
                  begin
                     state_reg <= S_WRITE;
                     req_reg   <= 1'b1;
                  end
                  else if (ctl_data[`SMT_REN_BIT])
                     state_reg <= S_RSTRT;
               end
            end
            S_WRITE:
            begin
               // Walk every location, one pattern word each
               if (wr_step)
               begin
                  if (addr_reg == `SMT_LAST_ADDR)
                  begin
                     req_reg   <= 1'b0;
                     addr_reg  <= 26'h0000000;
                     state_reg <= ren_reg ? S_RSTRT : S_IDLE;
                  end
                  else
                     addr_reg <= addr_reg + 26'h0000001;
               end
            end
            S_RSTRT:
            begin
               // Read pass starts fresh from address zero
               addr_reg    <= 26'h0000000;
               last_rd_reg <= 1'b0;
               state_reg   <= S_READ;
            end
            S_READ:
            begin
               // Issue reads only while the output has room
               if (mem_read && mem_ack)
               begin
                  if (addr_reg == `SMT_LAST_ADDR)
                  begin
                     last_rd_reg <= 1'b1;
                     state_reg   <= S_DRAIN;
                  end
                  else
                     addr_reg <= addr_reg + 26'h0000001;
               end
               if (rd_step)
                  rcnt_reg <= rcnt_reg + 26'h0000001;
            end
            S_DRAIN:
            begin
               // Wait for the last returned word
               if (rd_step)
               begin
                  rcnt_reg <= rcnt_reg + 26'h0000001;
                  if (rcnt_reg == `SMT_LAST_ADDR)
                     state_reg <= S_IDLE;
               end
            end
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   // Memory requests; reads held off while output is full
   assign mem_addr  = addr_reg;
   assign mem_wdata = wr_pat;
   assign mem_write = (state_reg == S_WRITE) && req_reg;
   assign mem_read  = (state_reg == S_READ) && !out_full;
   assign busy      = (state_reg != S_IDLE);

   // Every read word goes out, checked or not; memory returns data only
   // for requests issued while room existed
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         out_data_reg  <= 32'h00000000;
         out_valid_reg <= 1'b0;
      end
      else
      begin
         out_valid_reg <= rd_step;
         if (rd_step)
            out_data_reg <= mem_rdata;
      end
   end
   assign out_data  = out_data_reg;
   assign out_valid = out_valid_reg;

   // Mismatch latch, cleared only by reset
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         err_reg <= 1'b0;
      else if (mismatch)
         err_reg <= 1'b1;
   end

   // Pattern LEDs show select bits, all lit after an error
   assign pattern_leds = err_reg ? 4'hf : sel_reg;

   // Sticky status, set wins over write-one-to-clear
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sts_reg  <= 3'h0;
         mask_reg <= 3'h0;
      end
      else
      begin
         if (reg_write && reg_addr == A_STATUS)
            sts_reg <= (sts_reg & ~reg_wdata[2:0]) |
                       {out_valid_reg, err_ev, done_ev};
         else
            sts_reg <= sts_reg | {out_valid_reg, err_ev, done_ev};
         if (reg_write && reg_addr == A_MASK)
            mask_reg <= reg_wdata[2:0];
      end
   end
   assign irq = |(sts_reg & mask_reg);

   // Read data one cycle after the strobe; unmapped reads zero
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         rdata_reg <= 32'h00000000;
      else if (reg_read)
      begin
         case (reg_addr)
            A_STATUS: rdata_reg <= {29'h0, sts_reg};
            A_MASK:   rdata_reg <= {29'h0, mask_reg};
            A_STATE:  rdata_reg <= {20'h0, err_reg, ren_reg, sel_reg,
                                    fast_fifo_clock_flag, last_rd_reg,
                                    1'b0, state_reg};
            default:  rdata_reg <= 32'h00000000;
         endcase
      end
      else
         rdata_reg <= 32'h00000000;
   end
   assign reg_rdata = rdata_reg;
endmodule

// >>> verilog/smt_pattern_gen.v
`timescale 1ns/1ps
`include "smt_consts.vh"
// Expected-data generator; one copy for writes, one for checks
module smt_pattern_gen
(
   input  wire        clk,
   input  wire        reset,
   input  wire        load,
   input  wire [3:0]  sel,
   input  wire        step,
   output wire [31:0] value
);
   reg [31:0] value_reg;   // Current pattern word
   reg [31:0] value_next;  // Next pattern word

   // Start value on load, advance on step
   always @*
   begin
      value_next = value_reg;
      if (load)
      begin
         case (sel)
            `SMT_PAT_ZERO:  value_next = `SMT_VAL_ZERO;
            `SMT_PAT_ONES:  value_next = `SMT_VAL_ONES;
            `SMT_PAT_FIVES: value_next = `SMT_VAL_FIVES;
            `SMT_PAT_AS:    value_next = `SMT_VAL_AS;
            `SMT_PAT_COUNT: value_next = `SMT_VAL_ZERO;
            `SMT_PAT_WALK:  value_next = `SMT_VAL_WALK0;
            default:        value_next = `SMT_VAL_ZERO;  // Unlisted codes
         endcase
      end
      else if (step)
      begin
         if (sel == `SMT_PAT_COUNT)
            value_next = value_reg + 32'h00000001;
         else if (sel == `SMT_PAT_WALK)
         begin
            if (value_reg == `SMT_VAL_WTOP)
               value_next = `SMT_VAL_WALK0;
            else
               value_next = {value_reg[30:0], 1'b0};
         end
      end
   end

   // Pattern register
   always @(posedge clk or posedge reset)
   begin
      if (reset)
         value_reg <= 32'h00000000;
      else
         value_reg <= value_next;
   end

   assign value = value_reg;
endmodule
